// *** core/xcvr_defs.vh ***
// constants for the registered octal bus transceiver
`ifndef XCVR_DEFS_VH
`define XCVR_DEFS_VH

// ----------------------------------------
// widths
// ----------------------------------------
`define PORT_W          8
`define ADDR_W          12
`define DATA_W          32
`define CNT_W           16

// ----------------------------------------
// register byte offsets
// ----------------------------------------
`define OFS_CTRL        12'h000
`define OFS_STATUS      12'h004
`define OFS_COUNT       12'h008
`define OFS_LIVE        12'h00C

// ----------------------------------------
// control fields (write one to act)
// ----------------------------------------
`define CTRL_SOFT_AB    0
`define CTRL_SOFT_BA    1
`define CTRL_CLR_CNT    2

// ----------------------------------------
// status fields
// ----------------------------------------
`define ST_AB_LSB       0
`define ST_BA_LSB       8
`define ST_DRIVE_A      16
`define ST_DRIVE_B      17
`define ST_SEEN_AB      18
`define ST_SEEN_BA      19

// ----------------------------------------
// count and live fields
// ----------------------------------------
`define CNT_AB_LSB      0
`define CNT_BA_LSB      16
`define LIVE_A_LSB      0
`define LIVE_B_LSB      8

// ----------------------------------------
// reset values and the count increment
// ----------------------------------------
`define RST_BYTE        8'h00
`define RST_WORD        32'h00000000
`define RST_CNT         16'h0000
`define CNT_ONE         16'h0001

`endif

// *** core/capture_edge.v ***
// rising-edge finder for one capture clock input
`timescale 1ns/100ps
module capture_edge (
   // clock and reset
   input  wire clk,
   input  wire rst_n,
   // capture clock level
   input  wire level_in,
   // one-cycle pulse on a rising edge
   output wire rise
);
   reg cur_q;
   reg prev_q;

   // prev resets high so a clock already high at release gives no false edge
   always @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         cur_q  <= 1'b1;
         prev_q <= 1'b1;
      end else begin
         cur_q  <= level_in;
         prev_q <= cur_q;
      end
   end

   assign rise = cur_q & ~prev_q;
endmodule

// *** core/data_store.v ***
// eight-bit storage register with no reset
`timescale 1ns/100ps
`include "xcvr_defs.vh"
module data_store (
   // clock
   input  wire                 clk,
   // load strobe and data
   input  wire                 load,
   input  wire [`PORT_W-1:0]   din,
   // stored value
   output reg  [`PORT_W-1:0]   dout
);
   // no reset: contents are unknown until the first load
   always @(posedge clk) begin
      if (load) begin
         dout <= din;
      end
   end
endmodule

// *** core/octal_registered_bus_transceiver.v ***
// top of the registered octal bus transceiver with apb status access
//
// Behaviour
// R1: two eight-bit ports, one register per direction
// R2: capture clock rise loads its source port
// R3: capture never gated by enable or direction
// R4: disabled drives nothing; no edge holds registers
// R5: isolation stores each port independently, both together
// R6: enabled, dir low, select low: live B to A
// R7: enabled, dir low, select high: stored B to A
// R8: enabled, dir high, select low: live A to B
// R9: enabled, dir high, select high: stored A to B
// R10: only one port driven, chosen by direction
// R11: undriven port may be captured into either register
// R12: opposite port level at capture is unspecified
// R13: storage registers have no reset
//
// Our own choices: the address map and register access over APB.
`timescale 1ns/100ps
`include "xcvr_defs.vh"
module octal_registered_bus_transceiver (
   // clock and reset
   input  wire                 REF_CLK,
   input  wire                 RST_B,
   // apb slave
   input  wire                 PSEL,
   input  wire                 PENABLE,
   input  wire                 PWRITE,
   input  wire [`ADDR_W-1:0]   PADDR,
   input  wire [`DATA_W-1:0]   PWDATA,
   output reg  [`DATA_W-1:0]   PRDATA,
   output reg                  PREADY,
   output reg                  PSLVERR,
   // control pins
   input  wire                 A_TO_B_CAPTURE_CLOCK,
   input  wire                 B_TO_A_CAPTURE_CLOCK,
   input  wire                 DRIVE_ENABLE_B,
   input  wire                 DIRECTION,
   input  wire                 A_PORT_SOURCE_SELECT,
   input  wire                 B_PORT_SOURCE_SELECT,
   // port a pins
   input  wire [`PORT_W-1:0]   PORT_A_BITS_IN,
   output reg  [`PORT_W-1:0]   PORT_A_BITS_OUT,
   output reg                  PORT_A_BITS_OE_B,
   // port b pins
   input  wire [`PORT_W-1:0]   PORT_B_BITS_IN,
   output reg  [`PORT_W-1:0]   PORT_B_BITS_OUT,
   output reg                  PORT_B_BITS_OE_B
);

   // ----------------------------------------
   // helper functions
   // ----------------------------------------

   // port a is the target when enabled and direction low
   function drives_a;
      input enable_b;
      input dir;
      begin
         drives_a = ~enable_b & ~dir;
      end
   endfunction

   // port b is the target when enabled and direction high
   function drives_b;
      input enable_b;
      input dir;
      begin
         drives_b = ~enable_b & dir;
      end
   endfunction

   // pick stored or live data for a driven port
   function [`PORT_W-1:0] pick_source;
      input               stored_sel;
      input [`PORT_W-1:0] stored;
      input [`PORT_W-1:0] live;
      begin
         pick_source = stored_sel ? stored : live;
      end
   endfunction

   // one register offset match on the apb address
   function addr_hit;
      input [`ADDR_W-1:0] addr;
      input [`ADDR_W-1:0] offset;
      begin
         addr_hit = (addr == offset);
      end
   endfunction

   // control bit written as one in a completing control write
   function ctrl_strobe;
      input wr;
      input hit;
      input bit_val;
      begin
         ctrl_strobe = wr & hit & bit_val;
      end
   endfunction

   // ----------------------------------------
   // reset release
   // ----------------------------------------
   reg rst_meta_q;
   reg rst_sync_q;

   // async assert, release through two stages
   always @(posedge REF_CLK or negedge RST_B) begin
      if (!RST_B) begin
         rst_meta_q <= 1'b0;
         rst_sync_q <= 1'b0;
      end else begin
         rst_meta_q <= 1'b1;
         rst_sync_q <= rst_meta_q;
      end
   end

   wire rst_n;
   assign rst_n = rst_sync_q;

   // ----------------------------------------
   // pin sampling
   // ----------------------------------------
   // data sampled on the same edge as the capture clock levels, so the
   // pulse from capture_edge lines up with the bus value it should store
   reg [`PORT_W-1:0] port_a_q;
   reg [`PORT_W-1:0] port_b_q;

   always @(posedge REF_CLK or negedge rst_n) begin
      if (!rst_n) begin
         port_a_q <= `RST_BYTE;
         port_b_q <= `RST_BYTE;
      end else begin
         port_a_q <= PORT_A_BITS_IN;
         port_b_q <= PORT_B_BITS_IN;
      end
   end

   // ----------------------------------------
   // capture edges
   // ----------------------------------------
   wire ab_rise;
   wire ba_rise;

   capture_edge u_ab_edge (
      .clk      (REF_CLK),
      .rst_n    (rst_n),
      .level_in (A_TO_B_CAPTURE_CLOCK),
      .rise     (ab_rise)
   );

   capture_edge u_ba_edge (
      .clk      (REF_CLK),
      .rst_n    (rst_n),
      .level_in (B_TO_A_CAPTURE_CLOCK),
      .rise     (ba_rise)
   );

   // ----------------------------------------
   // apb decode
   // ----------------------------------------
   wire apb_access;
   wire apb_done;
   wire apb_wr;
   wire hit_ctrl;
   wire hit_status;
   wire hit_count;
   wire hit_live;
   wire hit_any;

   // one wait state: pready rises in the second access cycle
   assign apb_access = PSEL & PENABLE;
   assign apb_done   = apb_access & PREADY;
   assign apb_wr     = apb_done & PWRITE;
   assign hit_ctrl   = addr_hit(PADDR, `OFS_CTRL);
   assign hit_status = addr_hit(PADDR, `OFS_STATUS);
   assign hit_count  = addr_hit(PADDR, `OFS_COUNT);
   assign hit_live   = addr_hit(PADDR, `OFS_LIVE);
   assign hit_any    = hit_ctrl | hit_status | hit_count | hit_live;

   // software capture strobes act exactly like a capture clock rise
   wire soft_ab;
   wire soft_ba;
   wire soft_clr;

   assign soft_ab  = ctrl_strobe(apb_wr, hit_ctrl, PWDATA[`CTRL_SOFT_AB]);
   assign soft_ba  = ctrl_strobe(apb_wr, hit_ctrl, PWDATA[`CTRL_SOFT_BA]);
   assign soft_clr = ctrl_strobe(apb_wr, hit_ctrl, PWDATA[`CTRL_CLR_CNT]);

   // ----------------------------------------
   // storage registers
   // ----------------------------------------
   wire              load_ab;
   wire              load_ba;
   wire [`PORT_W-1:0] stored_ab;
   wire [`PORT_W-1:0] stored_ba;

   // no enable or direction term here: capture is always live
   assign load_ab = ab_rise | soft_ab;  // [R2] [R3] [R11]
   assign load_ba = ba_rise | soft_ba;  // [R2] [R3] [R11]

   // separate stores so both can load in one cycle
   data_store u_ab_store (
      .clk  (REF_CLK),
      .load (load_ab),                  // [R5]
      .din  (port_a_q),                 // [R1]
      .dout (stored_ab)
   );

   data_store u_ba_store (
      .clk  (REF_CLK),
      .load (load_ba),                  // [R4] [R5]
      .din  (port_b_q),                 // [R1]
      .dout (stored_ba)
   );

   // ----------------------------------------
   // capture bookkeeping
   // ----------------------------------------
   // storage has no reset, so software sees whether it is valid yet
   reg                seen_ab_q;
   reg                seen_ba_q;
   reg                seen_ab_d;
   reg                seen_ba_d;
   reg [`CNT_W-1:0]   cnt_ab_q;
   reg [`CNT_W-1:0]   cnt_ba_q;
   reg [`CNT_W-1:0]   cnt_ab_d;
   reg [`CNT_W-1:0]   cnt_ba_d;

   always @* begin
      seen_ab_d = seen_ab_q | load_ab;  // [R13]
      seen_ba_d = seen_ba_q | load_ba;  // [R13]
      cnt_ab_d  = cnt_ab_q;
      cnt_ba_d  = cnt_ba_q;
      // a capture in the clearing cycle still counts once
      if (soft_clr) begin
         cnt_ab_d = `RST_CNT;
         cnt_ba_d = `RST_CNT;
      end
      if (load_ab) begin
         cnt_ab_d = cnt_ab_d + `CNT_ONE;
      end
      if (load_ba) begin
         cnt_ba_d = cnt_ba_d + `CNT_ONE;
      end
   end

   always @(posedge REF_CLK or negedge rst_n) begin
      if (!rst_n) begin
         seen_ab_q <= 1'b0;
         seen_ba_q <= 1'b0;
         cnt_ab_q  <= `RST_CNT;
         cnt_ba_q  <= `RST_CNT;
      end else begin
         seen_ab_q <= seen_ab_d;
         seen_ba_q <= seen_ba_d;
         cnt_ab_q  <= cnt_ab_d;
         cnt_ba_q  <= cnt_ba_d;
      end
   end

   // ----------------------------------------
   // output steering
   // ----------------------------------------
   // live data passes through two flops, so live mode lags the far bus by
   // two clocks; the trade is clean registered pins against that latency
   reg                a_oe_b_d;
   reg                b_oe_b_d;
   reg [`PORT_W-1:0]  a_out_d;
   reg [`PORT_W-1:0]  b_out_d;

   always @* begin
      a_oe_b_d = 1'b1;
      b_oe_b_d = 1'b1;
      a_out_d  = PORT_A_BITS_OUT;
      b_out_d  = PORT_B_BITS_OUT;
      // a disabled enable leaves both ports released
      if (drives_a(DRIVE_ENABLE_B, DIRECTION)) begin                          // [R4] [R10]
         a_oe_b_d = 1'b0;
         a_out_d  = pick_source(A_PORT_SOURCE_SELECT, stored_ba, port_b_q);  // [R6] [R7]
      end
      if (drives_b(DRIVE_ENABLE_B, DIRECTION)) begin                          // [R4] [R10]
         b_oe_b_d = 1'b0;
         b_out_d  = pick_source(B_PORT_SOURCE_SELECT, stored_ab, port_a_q);  // [R8] [R9]
      end
   end

   // the port opposite a capture simply follows this steering [R12]
   always @(posedge REF_CLK or negedge rst_n) begin
      if (!rst_n) begin
         PORT_A_BITS_OE_B <= 1'b1;
         PORT_B_BITS_OE_B <= 1'b1;
         PORT_A_BITS_OUT  <= `RST_BYTE;
         PORT_B_BITS_OUT  <= `RST_BYTE;
      end else begin
         PORT_A_BITS_OE_B <= a_oe_b_d;
         PORT_B_BITS_OE_B <= b_oe_b_d;
         PORT_A_BITS_OUT  <= a_out_d;
         PORT_B_BITS_OUT  <= b_out_d;
      end
   end

   // ----------------------------------------
   // apb read and answer
   // ----------------------------------------
   reg [`DATA_W-1:0] rdata_d;

   always @* begin
      rdata_d = `RST_WORD;
      if (hit_status) begin
         rdata_d[`ST_AB_LSB +: `PORT_W] = stored_ab;
         rdata_d[`ST_BA_LSB +: `PORT_W] = stored_ba;
         rdata_d[`ST_DRIVE_A]           = ~PORT_A_BITS_OE_B;
         rdata_d[`ST_DRIVE_B]           = ~PORT_B_BITS_OE_B;
         rdata_d[`ST_SEEN_AB]           = seen_ab_q;
         rdata_d[`ST_SEEN_BA]           = seen_ba_q;
      end else if (hit_count) begin
         rdata_d[`CNT_AB_LSB +: `CNT_W] = cnt_ab_q;
         rdata_d[`CNT_BA_LSB +: `CNT_W] = cnt_ba_q;
      end else if (hit_live) begin
         rdata_d[`LIVE_A_LSB +: `PORT_W] = port_a_q;
         rdata_d[`LIVE_B_LSB +: `PORT_W] = port_b_q;
      end
   end

   // pslverr, pready and, on reads only, prdata are loaded at the end of the first access
   // cycle; pready drops right after the completing edge
   always @(posedge REF_CLK or negedge rst_n) begin
      if (!rst_n) begin
         PREADY  <= 1'b0;
         PSLVERR <= 1'b0;
         PRDATA  <= `RST_WORD;
      end else begin
         PREADY <= apb_access & ~PREADY;
         if (apb_access & ~PREADY) begin
            PSLVERR <= ~hit_any;
            if (!PWRITE) begin
               PRDATA <= rdata_d;
            end
         end else begin
            PSLVERR <= 1'b0;
         end
      end
   end

endmodule

// *** bench/xcvr_checker_properties.sv ***
// pin and apb relations of the registered octal transceiver
`timescale 1ns/100ps
`include "xcvr_defs.vh"
module xcvr_checker (
   // clock and reset
   input wire                 REF_CLK,
   input wire                 RST_B,
   // apb
   input wire                 PSEL,
   input wire                 PENABLE,
   input wire                 PWRITE,
   input wire [`ADDR_W-1:0]   PADDR,
   input wire [`DATA_W-1:0]   PWDATA,
   input wire [`DATA_W-1:0]   PRDATA,
   input wire                 PREADY,
   input wire                 PSLVERR,
   // control pins
   input wire                 A_TO_B_CAPTURE_CLOCK,
   input wire                 B_TO_A_CAPTURE_CLOCK,
   input wire                 DRIVE_ENABLE_B,
   input wire                 DIRECTION,
   input wire                 A_PORT_SOURCE_SELECT,
   input wire                 B_PORT_SOURCE_SELECT,
   // ports
   input wire [`PORT_W-1:0]   PORT_A_BITS_IN,
   input wire [`PORT_W-1:0]   PORT_A_BITS_OUT,
   input wire                 PORT_A_BITS_OE_B,
   input wire [`PORT_W-1:0]   PORT_B_BITS_IN,
   input wire [`PORT_W-1:0]   PORT_B_BITS_OUT,
   input wire                 PORT_B_BITS_OE_B
);
   // ----
   // modes
   // ----
   wire en = !DRIVE_ENABLE_B;
   wire la = en & !DIRECTION & !A_PORT_SOURCE_SELECT;
   wire sa = en & !DIRECTION & A_PORT_SOURCE_SELECT;
   wire lb = en & DIRECTION & !B_PORT_SOURCE_SELECT;
   wire sb = en & DIRECTION & B_PORT_SOURCE_SELECT;
   default clocking @(posedge REF_CLK); endclocking
   default disable iff (!RST_B);
   property p_one_side; !(!PORT_A_BITS_OE_B && !PORT_B_BITS_OE_B); endproperty
   a_one_side: assert property (p_one_side) else $error("both ports driven");
   property p_off; $past(DRIVE_ENABLE_B) |-> PORT_A_BITS_OE_B && PORT_B_BITS_OE_B; endproperty
   a_off: assert property (p_off) else $error("driving while disabled");
   property p_dir;
      $past(en) |-> PORT_A_BITS_OE_B == $past(DIRECTION) && PORT_B_BITS_OE_B == !$past(DIRECTION);
   endproperty
   a_dir: assert property (p_dir) else $error("wrong port driven");
   property p_live_a; $past(la) |-> PORT_A_BITS_OUT == $past(PORT_B_BITS_IN, 2); endproperty
   a_live_a: assert property (p_live_a) else $error("port a not live b");
   property p_live_b; $past(lb) |-> PORT_B_BITS_OUT == $past(PORT_A_BITS_IN, 2); endproperty
   a_live_b: assert property (p_live_b) else $error("port b not live a");
   // stored output may only move after a capture
   property p_hold_a;
      $past(sa) && $past(sa, 2) && !$past(B_TO_A_CAPTURE_CLOCK) && !$past(B_TO_A_CAPTURE_CLOCK, 2)
         && !$past(B_TO_A_CAPTURE_CLOCK, 3) && !($past(PSEL, 2) && $past(PWRITE, 2))
         |-> $stable(PORT_A_BITS_OUT);
   endproperty
   a_hold_a: assert property (p_hold_a) else $error("stored a moved");
   property p_hold_b;
      $past(sb) && $past(sb, 2) && !$past(A_TO_B_CAPTURE_CLOCK) && !$past(A_TO_B_CAPTURE_CLOCK, 2)
         && !$past(A_TO_B_CAPTURE_CLOCK, 3) && !($past(PSEL, 2) && $past(PWRITE, 2))
         |-> $stable(PORT_B_BITS_OUT);
   endproperty
   a_hold_b: assert property (p_hold_b) else $error("stored b moved");
   property p_wait; PSEL && PENABLE && !PREADY |=> PREADY; endproperty
   a_wait: assert property (p_wait) else $error("ready late");
   property p_err; PSLVERR |-> PREADY; endproperty
   a_err: assert property (p_err) else $error("error without ready");
   c_live_a: cover property (la ##2 la);
   c_stored_b: cover property (sb ##3 sb);
   c_both: cover property (A_TO_B_CAPTURE_CLOCK && B_TO_A_CAPTURE_CLOCK);
endmodule
bind octal_registered_bus_transceiver xcvr_checker i_xcvr_checker (
   .REF_CLK(REF_CLK), .RST_B(RST_B), .PSEL(PSEL), .PENABLE(PENABLE), .PWRITE(PWRITE),
   .PADDR(PADDR), .PWDATA(PWDATA), .PRDATA(PRDATA), .PREADY(PREADY), .PSLVERR(PSLVERR),
   .A_TO_B_CAPTURE_CLOCK(A_TO_B_CAPTURE_CLOCK), .B_TO_A_CAPTURE_CLOCK(B_TO_A_CAPTURE_CLOCK),
   .DRIVE_ENABLE_B(DRIVE_ENABLE_B), .DIRECTION(DIRECTION),
   .A_PORT_SOURCE_SELECT(A_PORT_SOURCE_SELECT), .B_PORT_SOURCE_SELECT(B_PORT_SOURCE_SELECT),
   .PORT_A_BITS_IN(PORT_A_BITS_IN), .PORT_A_BITS_OUT(PORT_A_BITS_OUT),
   .PORT_A_BITS_OE_B(PORT_A_BITS_OE_B), .PORT_B_BITS_IN(PORT_B_BITS_IN),
   .PORT_B_BITS_OUT(PORT_B_BITS_OUT), .PORT_B_BITS_OE_B(PORT_B_BITS_OE_B));

// *** bench/bus_partner.sv ***
// far-side logic on buses a and b
`timescale 1ns/100ps
module bus_partner (
   // far-side values
   input wire [7:0]  a_drive,
   input wire [7:0]  b_drive,
   // device side
   input wire [7:0]  a_out,
   input wire        a_oe_b,
   input wire [7:0]  b_out,
   input wire        b_oe_b,
   // resolved pins
   output wire [7:0] a_pin,
   output wire [7:0] b_pin
);
   // far side backs off whenever the device drives, so no contention
   assign a_pin = a_oe_b ? a_drive : a_out;
   assign b_pin = b_oe_b ? b_drive : b_out;
endmodule

// *** bench/octal_registered_bus_transceiver_bench.sv ***
// directed bench for the registered octal transceiver
`timescale 1ns/100ps
`include "xcvr_defs.vh"
`define CHK(g, e) begin comparisons++; if ((g) !== (e)) begin failures++; \
   $display("wrong value at %0t: got %h want %h", $time, g, e); end end
module octal_registered_bus_transceiver_bench;
   logic          clk, rst_b, psel, penable, pwrite, pready, pslverr, err;
   logic          cab, cba, en_b, dir, sel_a, sel_b, a_oe_b, b_oe_b;
   logic [11:0]   paddr;
   logic [31:0]   pwdata, prdata, rd;
   logic [7:0]    a_ext, b_ext, a_out, b_out, a_pin, b_pin;
   int            failures, comparisons;
   // ----
   // design and far side
   // ----
   octal_registered_bus_transceiver i_octal_registered_bus_transceiver (
      .REF_CLK(clk), .RST_B(rst_b), .PSEL(psel), .PENABLE(penable), .PWRITE(pwrite),
      .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready), .PSLVERR(pslverr),
      .A_TO_B_CAPTURE_CLOCK(cab), .B_TO_A_CAPTURE_CLOCK(cba), .DRIVE_ENABLE_B(en_b),
      .DIRECTION(dir), .A_PORT_SOURCE_SELECT(sel_a), .B_PORT_SOURCE_SELECT(sel_b),
      .PORT_A_BITS_IN(a_pin), .PORT_A_BITS_OUT(a_out), .PORT_A_BITS_OE_B(a_oe_b),
      .PORT_B_BITS_IN(b_pin), .PORT_B_BITS_OUT(b_out), .PORT_B_BITS_OE_B(b_oe_b));
   bus_partner i_bus_partner (.a_drive(a_ext), .b_drive(b_ext), .a_out(a_out), .a_oe_b(a_oe_b),
      .b_out(b_out), .b_oe_b(b_oe_b), .a_pin(a_pin), .b_pin(b_pin));
   initial begin
      clk = 0;
      forever #12.5 clk = ~clk;
   end
   task results;
      $display("comparisons %0d failures %0d", comparisons, failures);
      if (failures == 0 && comparisons > 0)
         $display("Simulation passed");
      else
         $display("Simulation failed");
      $finish;
   endtask
   task tick(input int n);
      repeat (n) @(posedge clk);
   endtask
   // one apb transfer, bounded wait on ready
   task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
      int n;
      psel <= 1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge clk);
      penable <= 1;
      n = 0;
      do begin
         @(posedge clk);
         n++;
      end while (pready !== 1'b1 && n < 16);
      if (pready !== 1'b1) begin
         failures++;
         $display("wrong value at %0t: no ready from apb", $time);
         results;
      end else begin
         rd = prdata;
         err = pslverr;
         psel <= 0;
         penable <= 0;
         @(posedge clk);
      end
   endtask
   task cap(input logic ab, input logic ba);
      cab <= ab;
      cba <= ba;
      @(posedge clk);
      cab <= 0;
      cba <= 0;
      @(posedge clk);
   endtask
   task s_reset;
      `CHK({a_oe_b, b_oe_b}, 2'b11)
      apb(0, `OFS_STATUS, 0);
      `CHK(rd[19:18], 2'b00)
      apb(0, 12'h010, 0);
      `CHK(err, 1'b1)
   endtask
   task s_isolate;
      a_ext <= 8'h5A;
      b_ext <= 8'hC3;
      cap(1, 1);
      apb(0, `OFS_STATUS, 0);
      `CHK(rd[19:0], 20'hCC35A)
      apb(0, `OFS_COUNT, 0);
      `CHK(rd, 32'h00010001)
      a_ext <= 8'h0F;
      b_ext <= 8'hF0;
      tick(3);
      apb(0, `OFS_STATUS, 0);
      `CHK(rd[15:0], 16'hC35A)
      apb(1, `OFS_CTRL, 32'h3);
      apb(0, `OFS_STATUS, 0);
      `CHK(rd[15:0], 16'hF00F)
      apb(0, `OFS_COUNT, 0);
      `CHK(rd, 32'h00020002)
      apb(0, `OFS_LIVE, 0);
      `CHK(rd, 32'h0000F00F)
      apb(1, `OFS_COUNT, 32'hFFFFFFFF);
      `CHK(err, 1'b0)
      apb(1, `OFS_CTRL, 32'h5);
      apb(0, `OFS_COUNT, 0);
      `CHK(rd, 32'h00000001)
   endtask
   task s_live;
      en_b <= 0;
      b_ext <= 8'h3C;
      tick(4);
      `CHK({a_oe_b, b_oe_b, a_pin}, {2'b01, 8'h3C})
      dir <= 1;
      a_ext <= 8'h96;
      tick(4);
      `CHK({a_oe_b, b_oe_b, b_pin}, {2'b10, 8'h96})
   endtask
   task s_stored;
      a_ext <= 8'h11;
      cap(1, 0);
      sel_b <= 1;
      a_ext <= 8'h22;
      tick(4);
      `CHK(b_pin, 8'h11)
      dir <= 0;
      sel_a <= 1;
      b_ext <= 8'h77;
      tick(3);
      `CHK(a_pin, 8'hF0)
      cap(0, 1);
      tick(2);
      `CHK(a_pin, 8'h77)
      en_b <= 1;
      tick(3);
      `CHK({a_oe_b, b_oe_b}, 2'b11)
   endtask
   initial begin
      rst_b = 0;
      {psel, penable, pwrite, cab, cba, dir, sel_a, sel_b} = 8'h00;
      en_b = 1;
      paddr = 0;
      pwdata = 0;
      a_ext = 0;
      b_ext = 0;
      failures = 0;
      comparisons = 0;
      tick(8);
      rst_b <= 1;
      tick(3);
      s_reset;
      s_isolate;
      s_live;
      s_stored;
      results;
   end
endmodule
